// file: rtl/err_tally.sv
`timescale 1ns/1ps
module err_tally
	import plcp_rx_pkg::*;
#(
	parameter int WIDTH = COUNT_W
) (
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	input  wire logic             count_inc,
	input  wire logic             snapshot,
	output logic      [WIDTH-1:0] held,
	output logic                  running_nz
);
	logic [WIDTH-1:0] running;
	logic [WIDTH-1:0] next_running;

	// Saturation keeps a flood of errors from wrapping to a small figure.
	always_comb begin
		next_running = running;
		if (count_inc && (running != {WIDTH{1'b1}})) begin
			next_running = running + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			running <= '0;
			held    <= '0;
		end else if (snapshot) begin
			held    <= next_running;
			running <= '0;
		end else begin
			running <= next_running;
		end
	end

	assign running_nz = (running != '0);
endmodule : err_tally

// file: rtl/plcp_rx_pkg.sv
package plcp_rx_pkg;
	localparam int          DATA_W       = 16;
	localparam int          ADDR_W       = 8;
	localparam int          COUNT_W      = 16;
	localparam int          NUM_COUNTERS = 3;

	// Register offsets within the port.
	localparam logic [7:0]  CTRL_OFS     = 8'h62;
	localparam logic [7:0]  LIVE_OFS     = 8'h64;
	localparam logic [7:0]  LATCH1_OFS   = 8'h68;
	localparam logic [7:0]  LATCH2_OFS   = 8'h6A;
	localparam logic [7:0]  IRQ_EN1_OFS  = 8'h6C;
	localparam logic [7:0]  IRQ_EN2_OFS  = 8'h6E;
	localparam logic [7:0]  FRM_CNT_OFS  = 8'h70;
	localparam logic [7:0]  PAR_CNT_OFS  = 8'h72;
	localparam logic [7:0]  RE_CNT_OFS   = 8'h74;
	localparam logic [7:0]  F1_G1_OFS    = 8'h76;

	// Reset values.
	localparam logic [15:0] REG_RESET    = 16'h0000;

	// Control register fields.
	localparam int          ECC_BIT      = 1;
	localparam int          FCS_BIT      = 2;

	// First latched and enable register fields.
	localparam int          REM_ERR_BIT  = 13;
	localparam int          PAR_ERR_BIT  = 12;
	localparam int          FRM_ERR_BIT  = 11;
	localparam int          LOF_BIT      = 8;
	localparam int          REIC_BIT     = 5;
	localparam int          PEC_BIT      = 4;
	localparam int          FEC_BIT      = 3;
	localparam int          RAI_BIT      = 2;
	localparam int          COFA_BIT     = 1;
	localparam int          OOF_BIT      = 0;
	localparam logic [15:0] LATCH1_MASK  = 16'h393F;

	// Second latched and enable register fields.
	localparam int          OVH_LSB      = 2;
	localparam int          OVH_W        = 9;
	localparam int          LSS_BIT      = 1;
	localparam int          LSSU_BIT     = 0;
	localparam logic [15:0] LATCH2_MASK  = 16'h07FF;
	localparam logic [15:0] E3_OFF_MASK  = 16'h0700;

	// Field placement of the F1 and link status readback.
	localparam int          F1_LSB       = 8;
	localparam int          LSS_W        = 3;

	// Counter indices.
	localparam int          FRM_IDX      = 0;
	localparam int          PAR_IDX      = 1;
	localparam int          RE_IDX       = 2;

	// Full frames after recovery before parity counting resumes.
	localparam logic [1:0]  PARITY_RESUME_FRAMES = 2'd2;
endpackage : plcp_rx_pkg

// file: rtl/plcp_rx_status.sv
// Behaviour
// - parity irq needs enable 12, flag, port enable
// - framing irq needs enable 11, flag, port enable
// - frame loss irq needs enable 8
// - bits 5..3 gate count-nonzero flags
// - bits 2..0 gate alarm, alignment, out-of-frame changes
// - zero suppresses, one allows each source
// - Z6..Z4 enables ignored in E3 mode
// - bits 7..5 gate Z3..Z1 changes
// - bits 4..2 gate M2, M1, F1 changes
// - bits 1..0 gate link status changes
// - sixteen bit framing error count readable
// - sixteen bit parity error count readable
// - sixteen bit remote error count readable
// - counters change only on monitor update
// - second enable and counters reset zero
// - parity error sets parity latched flag
// - any out-of-frame change sets its flag
// - no counting in out-of-frame unless enabled
// - select byte errors or out-of-frame events
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
module plcp_rx_status
	import plcp_rx_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output logic      [DATA_W-1:0] rd_data,
	input  wire logic              port_status_irq_en,
	input  wire logic              perf_monitor_update,
	input  wire logic              e3_mode,
	input  wire logic              frame_start,
	input  wire logic              out_of_frame,
	input  wire logic              loss_of_frame,
	input  wire logic              remote_alarm,
	input  wire logic              link_unstable,
	input  wire logic [LSS_W-1:0]  link_state,
	input  wire logic [7:0]        f1_byte,
	input  wire logic              framing_byte_err,
	input  wire logic              parity_err,
	input  wire logic              remote_err,
	input  wire logic              align_change,
	input  wire logic [OVH_W-1:0]  ovh_byte_change,
	output logic                   irq
);
	logic [DATA_W-1:0] ctrl;
	logic [DATA_W-1:0] irq_en1;
	logic [DATA_W-1:0] irq_en2;
	logic [DATA_W-1:0] latch1;
	logic [DATA_W-1:0] latch2;
	logic [DATA_W-1:0] next_latch1;
	logic [DATA_W-1:0] next_latch2;
	logic [DATA_W-1:0] set1;
	logic [DATA_W-1:0] set2;
	logic [DATA_W-1:0] en2_eff;
	logic [DATA_W-1:0] live;
	logic              oof_q;
	logic              lof_q;
	logic              rai_q;
	logic              lssu_q;
	logic [LSS_W-1:0]  lss_q;
	logic [1:0]        frames_ok;
	logic [2:0]        nz_q;
	logic [2:0]        cnt_nz;
	logic [2:0]        cnt_inc;
	logic [COUNT_W-1:0] cnt_held [NUM_COUNTERS];
	logic              ecc;
	logic              fcs;
	logic              count_ok;
	logic              parity_ok;
	logic              next_irq;

	assign ecc = ctrl[ECC_BIT];
	assign fcs = ctrl[FCS_BIT];

	// Software registers.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ctrl    <= REG_RESET;
			irq_en1 <= REG_RESET;
			irq_en2 <= REG_RESET;
		end else if (wr_en) begin
			unique case (addr)
				CTRL_OFS:    ctrl    <= wr_data;
				IRQ_EN1_OFS: irq_en1 <= wr_data & LATCH1_MASK;
				IRQ_EN2_OFS: irq_en2 <= wr_data & LATCH2_MASK;
				default:     ;
			endcase
		end
	end

	// Previous values of the live status for change detection.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			oof_q  <= 1'b0;
			lof_q  <= 1'b0;
			rai_q  <= 1'b0;
			lssu_q <= 1'b0;
			lss_q  <= '0;
			nz_q   <= '0;
		end else begin
			oof_q  <= out_of_frame;
			lof_q  <= loss_of_frame;
			rai_q  <= remote_alarm;
			lssu_q <= link_unstable;
			lss_q  <= link_state;
			nz_q   <= cnt_nz;
		end
	end

	// Parity counting waits for two full frames after framing returns.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			frames_ok <= 2'd0;
		end else if (out_of_frame) begin
			frames_ok <= 2'd0;
		end else if (frame_start && (frames_ok != PARITY_RESUME_FRAMES)) begin
			frames_ok <= frames_ok + 2'd1;
		end
	end

	assign count_ok  = ecc || !out_of_frame;
	assign parity_ok = ecc || (!out_of_frame && (frames_ok == PARITY_RESUME_FRAMES));

	always_comb begin
		cnt_inc = '0;
		if (fcs) begin
			cnt_inc[FRM_IDX] = out_of_frame && !oof_q;
		end else begin
			cnt_inc[FRM_IDX] = framing_byte_err && count_ok;
		end
		cnt_inc[PAR_IDX] = parity_err && parity_ok;
		cnt_inc[RE_IDX] = remote_err && count_ok;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_count
			err_tally #(
				.WIDTH(COUNT_W)
			) u_tally (
				.sys_clk   (sys_clk),
				.rst_n     (rst_n),
				.count_inc (cnt_inc[gi]),
				.snapshot  (perf_monitor_update),
				.held      (cnt_held[gi]),
				.running_nz(cnt_nz[gi])
			);
		end
	endgenerate

	// Events that set the latched flags.
	always_comb begin
		set1 = '0;
		set1[REM_ERR_BIT] = remote_err;
		set1[PAR_ERR_BIT] = parity_err;
		set1[FRM_ERR_BIT] = framing_byte_err;
		set1[LOF_BIT]  = loss_of_frame != lof_q;
		set1[REIC_BIT] = cnt_nz[RE_IDX] && !nz_q[RE_IDX];
		set1[PEC_BIT]  = cnt_nz[PAR_IDX] && !nz_q[PAR_IDX];
		set1[FEC_BIT]  = cnt_nz[FRM_IDX] && !nz_q[FRM_IDX];
		set1[RAI_BIT]  = remote_alarm != rai_q;
		set1[COFA_BIT] = align_change;
		set1[OOF_BIT]  = out_of_frame != oof_q;
		set2 = '0;
		set2[OVH_LSB +: OVH_W] = ovh_byte_change;
		set2[LSS_BIT]  = link_state != lss_q;
		set2[LSSU_BIT] = link_unstable != lssu_q;
		if (e3_mode) begin
			set2 = set2 & ~E3_OFF_MASK;
		end
	end

	// Write one to clear; a new event in the same cycle wins.
	always_comb begin
		next_latch1 = latch1 | set1;
		next_latch2 = latch2 | set2;
		if (wr_en && (addr == LATCH1_OFS)) begin
			next_latch1 = (latch1 & ~wr_data) | set1;
		end
		if (wr_en && (addr == LATCH2_OFS)) begin
			next_latch2 = (latch2 & ~wr_data) | set2;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			latch1 <= REG_RESET;
			latch2 <= REG_RESET;
		end else begin
			latch1 <= next_latch1 & LATCH1_MASK;
			latch2 <= next_latch2 & LATCH2_MASK;
		end
	end

	// Z6 to Z4 enables mean nothing on an E3 line.
	assign en2_eff = e3_mode ? (irq_en2 & ~E3_OFF_MASK) : irq_en2;

	// Each enable bit is a plain AND: one passes its flag, zero hides it; in E3 mode Z6 to Z4 pass nothing.
	assign next_irq = port_status_irq_en &&
		(|(latch1 & irq_en1) || |(latch2 & en2_eff));

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	always_comb begin
		live = '0;
		live[LOF_BIT]  = loss_of_frame;
		live[REIC_BIT] = cnt_nz[RE_IDX];
		live[PEC_BIT]  = cnt_nz[PAR_IDX];
		live[FEC_BIT]  = cnt_nz[FRM_IDX];
		live[RAI_BIT]  = remote_alarm;
		live[OOF_BIT]  = out_of_frame;
	end

	// Read data stand for exactly one cycle after the strobe.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else if (rd_en) begin
			unique case (addr)
				CTRL_OFS:    rd_data <= ctrl;
				LIVE_OFS:    rd_data <= live;
				LATCH1_OFS:  rd_data <= latch1;
				LATCH2_OFS:  rd_data <= latch2;
				IRQ_EN1_OFS: rd_data <= irq_en1;
				IRQ_EN2_OFS: rd_data <= irq_en2;
				FRM_CNT_OFS: rd_data <= cnt_held[FRM_IDX];
				PAR_CNT_OFS: rd_data <= cnt_held[PAR_IDX];
				RE_CNT_OFS:  rd_data <= cnt_held[RE_IDX];
				F1_G1_OFS:   rd_data <= {f1_byte, 5'h00, link_state};
				default:     rd_data <= '0;
			endcase
		end else begin
			rd_data <= '0;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	parity_irq_a: assert property (
		latch1[PAR_ERR_BIT] && irq_en1[PAR_ERR_BIT] && port_status_irq_en |=> irq)
		else $error("parity interrupt not raised");

	framing_irq_a: assert property (
		latch1[FRM_ERR_BIT] && irq_en1[FRM_ERR_BIT] && port_status_irq_en |=> irq)
		else $error("framing interrupt not raised");

	loss_irq_a: assert property (
		latch1[LOF_BIT] && irq_en1[LOF_BIT] && port_status_irq_en |=> irq)
		else $error("frame loss interrupt not raised");

	port_gate_a: assert property (
		!port_status_irq_en |=> !irq)
		else $error("interrupt without port enable");

	e3_mask_a: assert property (
		e3_mode && (latch1 & irq_en1) == '0 &&
		(latch2 & irq_en2 & ~E3_OFF_MASK) == '0 |=> !irq)
		else $error("E3 mode did not hide Z6 to Z4");

	parity_latch_a: assert property (
		parity_err |=> latch1[PAR_ERR_BIT])
		else $error("parity flag not latched");

	oof_latch_a: assert property (
		out_of_frame != $past(out_of_frame) |=> latch1[OOF_BIT])
		else $error("out of frame change not latched");

	count_hold_a: assert property (
		!perf_monitor_update |=> $stable(cnt_held[FRM_IDX]) &&
		$stable(cnt_held[PAR_IDX]) && $stable(cnt_held[RE_IDX]))
		else $error("counter moved without update");

	oof_block_a: assert property (
		!ecc && out_of_frame |-> !cnt_inc[PAR_IDX] && !cnt_inc[RE_IDX])
		else $error("error counted while out of frame");

	reset_zero_a: assert property (
		!$past(rst_n) |-> irq_en2 == '0 && cnt_held[FRM_IDX] == '0 &&
		cnt_held[PAR_IDX] == '0 && cnt_held[RE_IDX] == '0)
		else $error("register not zero after reset");

	irq_rise_c: cover property (!irq ##1 irq);
	update_c: cover property (perf_monitor_update && cnt_nz[PAR_IDX]);
	oof_event_c: cover property (fcs && cnt_inc[FRM_IDX]);
	e3_mode_c: cover property (e3_mode && ovh_byte_change[8]);
endmodule : plcp_rx_status

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import plcp_rx_pkg::*;
;
	logic              sys_clk, rst_n, wr_en, rd_en, port_status_irq_en;
	logic              perf_monitor_update, e3_mode, frame_start, out_of_frame;
	logic              loss_of_frame, remote_alarm, link_unstable, framing_byte_err;
	logic              parity_err, remote_err, align_change, irq;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wr_data, rd_data;
	logic [LSS_W-1:0]  link_state;
	logic [7:0]        f1_byte;
	logic [OVH_W-1:0]  ovh_byte_change;
	int                n_errors, n_compared, r, b;
	int                tab[20] = '{112, 111, 108, 105, 104, 103, 102, 101, 100,
		210, 209, 208, 207, 206, 205, 204, 203, 202, 201, 200};

	plcp_rx_status u_plcp_rx_status (.sys_clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en,
		.rd_data, .port_status_irq_en, .perf_monitor_update, .e3_mode, .frame_start,
		.out_of_frame, .loss_of_frame, .remote_alarm, .link_unstable, .link_state,
		.f1_byte, .framing_byte_err, .parity_err, .remote_err, .align_change,
		.ovh_byte_change, .irq);

	always #20 sys_clk = ~sys_clk;

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe; the next edge still sees them.
	task rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		@(posedge sys_clk);
		chk(rd_data, exp);
	endtask : rd

	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : cyc

	// Codes 14 and 15 give a frame start and a monitor update.
	task ev(input int rr, input int bb);
		@(posedge sys_clk);
		if (rr == 2 && bb >= 2) ovh_byte_change[bb-2] <= 1'b1;
		else if (rr == 2 && bb == 1) link_state <= link_state + 3'h1;
		else if (rr == 2) link_unstable <= !link_unstable;
		else case (bb)
			12, 4: parity_err <= 1'b1;
			11, 3: framing_byte_err <= 1'b1;
			8: loss_of_frame <= !loss_of_frame;
			5: remote_err <= 1'b1;
			2: remote_alarm <= !remote_alarm;
			1: align_change <= 1'b1;
			0: out_of_frame <= !out_of_frame;
			14: frame_start <= 1'b1;
			default: perf_monitor_update <= 1'b1;
		endcase
		@(posedge sys_clk);
		ovh_byte_change <= '0;
		parity_err <= 1'b0;
		framing_byte_err <= 1'b0;
		remote_err <= 1'b0;
		align_change <= 1'b0;
		frame_start <= 1'b0;
		perf_monitor_update <= 1'b0;
	endtask : ev

	task tally_and_finish;
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : tally_and_finish

	// The run needs about five hundred cycles; this limit leaves wide margin.
	initial begin
		#2000000;
		n_errors++;
		tally_and_finish();
	end

	initial begin
		{sys_clk, rst_n, wr_en, rd_en, port_status_irq_en, perf_monitor_update} = '0;
		{e3_mode, frame_start, out_of_frame, loss_of_frame, remote_alarm} = '0;
		{link_unstable, framing_byte_err, parity_err, remote_err, align_change} = '0;
		addr = 8'h00;
		wr_data = 16'h0000;
		link_state = 3'h0;
		f1_byte = 8'hA5;
		ovh_byte_change = '0;
		n_errors = 0;
		n_compared = 0;
		cyc(10);
		rst_n <= 1'b1;
		chk({15'h0, irq}, 16'h0000);
		rd(IRQ_EN2_OFS, 16'h0000);
		rd(FRM_CNT_OFS, 16'h0000);
		rd(PAR_CNT_OFS, 16'h0000);
		rd(RE_CNT_OFS, 16'h0000);
		rd(8'h80, 16'h0000);
		wr(IRQ_EN2_OFS, 16'hFFFF);
		rd(IRQ_EN2_OFS, 16'h07FF);
		wr(IRQ_EN2_OFS, 16'h0000);
		$display("reset and access test done");
		wr(CTRL_OFS, 16'h0002);
		wr(IRQ_EN1_OFS, 16'h1000);
		ev(1, 12);
		cyc(3);
		chk({15'h0, irq}, 16'h0000);
		port_status_irq_en <= 1'b1;
		cyc(3);
		chk({15'h0, irq}, 16'h0001);
		rd(LATCH1_OFS, 16'h1010);
		wr(IRQ_EN1_OFS, 16'h0000);
		wr(LATCH1_OFS, 16'hFFFF);
		ev(1, 15);
		$display("port gating test done");
		foreach (tab[i]) begin
			r = tab[i] / 100;
			b = tab[i] % 100;
			wr(r == 1 ? IRQ_EN1_OFS : IRQ_EN2_OFS, 16'h0001 << b);
			ev(r, b);
			cyc(3);
			chk({15'h0, irq}, 16'h0001);
			wr(r == 1 ? IRQ_EN1_OFS : IRQ_EN2_OFS, 16'h0000);
			cyc(2);
			chk({15'h0, irq}, 16'h0000);
			wr(LATCH1_OFS, 16'hFFFF);
			wr(LATCH2_OFS, 16'hFFFF);
			ev(1, 15);
		end
		$display("enable sweep test done");
		// A flag latched before E3 mode must stay hidden once the mode is on.
		ev(2, 10);
		e3_mode <= 1'b1;
		wr(IRQ_EN2_OFS, 16'h0700);
		cyc(3);
		chk({15'h0, irq}, 16'h0000);
		wr(LATCH2_OFS, 16'hFFFF);
		ev(2, 10);
		ev(2, 9);
		ev(2, 8);
		cyc(3);
		chk({15'h0, irq}, 16'h0000);
		rd(LATCH2_OFS, 16'h0000);
		wr(IRQ_EN2_OFS, 16'h0000);
		e3_mode <= 1'b0;
		$display("e3 test done");
		repeat (3) ev(1, 12);
		repeat (2) ev(1, 11);
		ev(1, 5);
		rd(PAR_CNT_OFS, 16'h0000);
		ev(1, 15);
		rd(FRM_CNT_OFS, 16'h0002);
		rd(PAR_CNT_OFS, 16'h0003);
		rd(RE_CNT_OFS, 16'h0001);
		wr(PAR_CNT_OFS, 16'hFFFF);
		rd(PAR_CNT_OFS, 16'h0003);
		ev(1, 15);
		rd(PAR_CNT_OFS, 16'h0000);
		$display("counter test done");
		// Out of frame is high here; with the control bit clear nothing counts.
		wr(CTRL_OFS, 16'h0000);
		ev(1, 12);
		ev(1, 11);
		ev(1, 5);
		ev(1, 0);
		ev(1, 11);
		ev(1, 5);
		ev(1, 12);
		ev(1, 14);
		ev(1, 12);
		ev(1, 14);
		ev(1, 12);
		ev(1, 15);
		rd(FRM_CNT_OFS, 16'h0001);
		rd(PAR_CNT_OFS, 16'h0001);
		rd(RE_CNT_OFS, 16'h0001);
		wr(CTRL_OFS, 16'h0006);
		repeat (4) ev(1, 0);
		ev(1, 11);
		ev(1, 15);
		rd(FRM_CNT_OFS, 16'h0002);
		rd(F1_G1_OFS, 16'hA501);
		rd(LIVE_OFS, 16'h0104);
		$display("count control test done");
		tally_and_finish();
	end
endmodule : tb_top
